/* File: src/ecfg_consts.svh */
// What this block does
// - Falling-edge enable set: falling pin edge triggers detector, else not.
// - Rising-edge enable set: rising pin edge triggers detector, else not.
// - Level field: 11 is 4.096 V, 10 is 2.048 V, 01 is 1.024 V, 00 off.
// - Highest level counts as valid only while supply is above it.
// - Source bit one routes internal level to ADC reference, zero supply.
// - Reset: both edge enables set, level field 01, source bit set.
`ifndef ECFG_CONSTS_SVH
`define ECFG_CONSTS_SVH
`define ECFG_ADDR_CFG     4'h0
`define ECFG_ADDR_STAT    4'h1
`define ECFG_ADDR_MASK    4'h2
`define ECFG_ADDR_LEVEL   4'h3
`define ECFG_BIT_FALL     6
`define ECFG_BIT_RISE     5
`define ECFG_BIT_LVL_HI   4
`define ECFG_BIT_LVL_LO   3
`define ECFG_BIT_SRC      2
`define ECFG_CFG_RST      8'h6c
`define ECFG_STAT_DET     0
`define ECFG_STAT_BADLVL  1
`endif

/* File: src/ecfg_pkg.sv */
package ecfg_pkg;
  typedef enum logic [1:0] {
    ECFG_LVL_OFF  = 2'h0,
    ECFG_LVL_1V0  = 2'h1,
    ECFG_LVL_2V0  = 2'h2,
    ECFG_LVL_4V1  = 2'h3
  } ecfg_lvl_e;
  typedef struct packed {
    logic [7:0] cfg;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [7:0] rdata;
  } ecfg_regs_s;
  typedef struct packed {
    logic [2:0] sync;
    logic       stable;
  } ecfg_edge_s;
endpackage

/* File: src/ecfg_edge_if.sv */
`timescale 1ns/10ps
interface ecfg_edge_if;
  logic pin;
  logic rise_en;
  logic fall_en;
  logic det_pulse;
  modport det (input pin, input rise_en, input fall_en, output det_pulse);
  modport ctl (output pin, output rise_en, output fall_en, input det_pulse);
endinterface

/* File: src/ecfg_edge_det.sv */
`timescale 1ns/10ps
module ecfg_edge_det
  import ecfg_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Detector link
  ecfg_edge_if.det e
);
  ecfg_edge_s st_ff;
  ecfg_edge_s nxt_st;
  logic       rise_hit;
  logic       fall_hit;
  logic       agree;

  // Only stages 1 and 2 are compared; stage 0 feeds stage 1 alone
  assign agree    = st_ff.sync[1] == st_ff.sync[2];
  assign rise_hit = agree && st_ff.sync[2] && !st_ff.stable;
  assign fall_hit = agree && !st_ff.sync[2] && st_ff.stable;
  assign e.det_pulse = (rise_hit && e.rise_en) ||
                       (fall_hit && e.fall_en);

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.sync = {st_ff.sync[1:0], e.pin};
    if (agree) begin
      nxt_st.stable = st_ff.sync[2];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  pulse_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
    e.det_pulse |=> !e.det_pulse)
    else $error("detect pulse longer than one cycle");
  no_en_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!e.rise_en && !e.fall_en) |-> !e.det_pulse)
    else $error("pulse with both enables off");
  fall_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fall_hit && !e.fall_en) |-> !e.det_pulse)
    else $error("falling edge passed while disabled");
  rise_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rise_hit && e.rise_en) |-> e.det_pulse)
    else $error("enabled rising edge missed");
endmodule

/* File: src/ecfg_top.sv */
`timescale 1ns/10ps
`include "ecfg_consts.svh"
module ecfg_top
  import ecfg_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  // Monitored pin and supply comparator
  input  wire logic       int_pin,
  input  wire logic       vdd_above_4v1,
  // Analog controls, detect pulse and interrupt
  output logic      [1:0] internal_ref_level,
  output logic            ref_level_valid,
  output logic            adc_ref_source_sel,
  output logic            edge_detect,
  output logic            irq
);
  import ecfg_pkg::*;

  ecfg_regs_s    r_ff;
  ecfg_regs_s    nxt_r;
  ecfg_edge_if   eif ();
  logic [2:0]    vdd_sync_ff;
  logic          vdd_ok;
  logic          bad_lvl;
  logic [1:0]    ev;
  ecfg_lvl_e     lvl;

  assign eif.pin     = int_pin;
  assign eif.fall_en = r_ff.cfg[`ECFG_BIT_FALL];
  assign eif.rise_en = r_ff.cfg[`ECFG_BIT_RISE];

  ecfg_edge_det u_det (
    .mclk  (mclk),
    .rst_n (rst_n),
    .e     (eif.det)
  );

  // Supply comparator is asynchronous; settle over three stages
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vdd_sync_ff <= 3'h0;
    end else begin
      vdd_sync_ff <= {vdd_sync_ff[1:0], vdd_above_4v1};
    end
  end
  assign vdd_ok = vdd_sync_ff[1] & vdd_sync_ff[2];

  assign lvl = ecfg_lvl_e'(r_ff.cfg[`ECFG_BIT_LVL_HI:`ECFG_BIT_LVL_LO]);
  // Top level without supply headroom is flagged, not silently used
  assign bad_lvl = (lvl == ECFG_LVL_4V1) && !vdd_ok;

  always_comb begin
    internal_ref_level = 2'h0;
    ref_level_valid    = 1'b0;
    unique case (lvl)
      ECFG_LVL_OFF: begin
        internal_ref_level = 2'h0;
        ref_level_valid    = 1'b0;
      end
      ECFG_LVL_1V0: begin
        internal_ref_level = 2'h1;
        ref_level_valid    = 1'b1;
      end
      ECFG_LVL_2V0: begin
        internal_ref_level = 2'h2;
        ref_level_valid    = 1'b1;
      end
      ECFG_LVL_4V1: begin
        internal_ref_level = 2'h3;
        ref_level_valid    = vdd_ok;
      end
    endcase
  end

  assign adc_ref_source_sel = r_ff.cfg[`ECFG_BIT_SRC];
  assign edge_detect        = eif.det_pulse;
  assign rdata              = r_ff.rdata;
  assign irq                = |(r_ff.stat & r_ff.mask);

  always_comb begin
    nxt_r = r_ff;
    ev    = {bad_lvl, eif.det_pulse};
    if (wr_stb) begin
      unique case (addr)
        `ECFG_ADDR_CFG: begin
          // Reserved top bit kept zero even if software slips
          nxt_r.cfg = {1'b0, wdata[6:0]};
        end
        `ECFG_ADDR_STAT: begin
          nxt_r.stat = r_ff.stat & ~wdata[1:0];
        end
        `ECFG_ADDR_MASK: begin
          nxt_r.mask = wdata[1:0];
        end
        default: begin
          nxt_r.cfg = r_ff.cfg;
        end
      endcase
    end
    // Set wins over a same-cycle clear
    nxt_r.stat = nxt_r.stat | ev;
    nxt_r.rdata = 8'h00;
    if (rd_stb) begin
      unique case (addr)
        `ECFG_ADDR_CFG:   nxt_r.rdata = r_ff.cfg;
        `ECFG_ADDR_STAT:  nxt_r.rdata = {6'h00, r_ff.stat};
        `ECFG_ADDR_MASK:  nxt_r.rdata = {6'h00, r_ff.mask};
        `ECFG_ADDR_LEVEL: nxt_r.rdata = {5'h00, ref_level_valid,
                                         internal_ref_level};
        default:          nxt_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r_ff       <= '0;
      r_ff.cfg   <= `ECFG_CFG_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  reset_val_a: assert property (@(posedge mclk)
    !rst_n |=> (r_ff.cfg == 8'h6c))
    else $error("config not at factory value after reset");
  lvl_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (r_ff.cfg[4:3] == 2'h0) |-> !ref_level_valid)
    else $error("reference valid while off");
  hi_lvl_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (r_ff.cfg[4:3] == 2'h3) |-> (ref_level_valid == vdd_ok))
    else $error("top level valid without supply");
  src_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_stb && addr == 4'h0) |=> (adc_ref_source_sel == $past(wdata[2])))
    else $error("source select did not follow write");
  rsv_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !r_ff.cfg[7])
    else $error("reserved bit set");
  det_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
    edge_detect |=> r_ff.stat[0])
    else $error("detect event lost");
endmodule

/* File: testbench/edge_detect_adc_ref_config_test.sv */
`timescale 1ns/10ps
module edge_detect_adc_ref_config_test;
  import ecfg_pkg::*;
  logic       mclk;
  logic       rst_n;
  logic       wr_stb;
  logic       rd_stb;
  logic       int_pin;
  logic       vdd_hi;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [1:0] lvl;
  logic       valid;
  logic       src;
  logic       det;
  logic       irq;
  int         error_cnt = 0;
  int         comparisons = 0;
  int         pulses = 0;
  int         p0;

  ecfg_top dut_u (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .int_pin(int_pin),
    .vdd_above_4v1(vdd_hi), .internal_ref_level(lvl),
    .ref_level_valid(valid), .adc_ref_source_sel(src),
    .edge_detect(det), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Counted per edge, so a stretched pulse shows as extra counts
  always @(posedge mclk) if (det === 1'b1) pulses <= pulses + 1;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Pin change, then room for sync fill plus the pulse
  task automatic pin(input logic v, input int exp);
    p0 = pulses;
    @(posedge mclk);
    int_pin <= v;
    repeat (8) @(posedge mclk);
    #1 chk(8'(pulses - p0), 8'(exp));
  endtask

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    wrap_up;
  end

  initial begin
    {rst_n, wr_stb, rd_stb, int_pin, vdd_hi} = 5'h0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h0, 8'h6c);
    chk({6'h0, lvl}, 8'h01);
    chk({7'h0, src}, 8'h01);
    rd(4'h3, 8'h05);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {3'h0, 2'(i), 3'h4});
      chk({6'h0, lvl}, 8'(i));
      chk({7'h0, valid}, 8'(i == 1 || i == 2));
    end
    rd(4'h1, 8'h02);
    chk({7'h0, irq}, 8'h00);
    wr(4'h2, 8'h03);
    chk({7'h0, irq}, 8'h01);
    @(posedge mclk);
    vdd_hi <= 1'b1;
    repeat (5) @(posedge mclk);
    #1 chk({7'h0, valid}, 8'h01);
    rd(4'h3, 8'h07);
    wr(4'h1, 8'h02);
    rd(4'h1, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(4'h0, 8'h80);
    rd(4'h0, 8'h00);
    chk({7'h0, src}, 8'h00);
    pin(1'b1, 0);
    pin(1'b0, 0);
    wr(4'h0, 8'h24);
    chk({7'h0, src}, 8'h01);
    pin(1'b1, 1);
    rd(4'h1, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(4'h1, 8'h01);
    pin(1'b0, 0);
    rd(4'h1, 8'h00);
    wr(4'h0, 8'h40);
    pin(1'b1, 0);
    pin(1'b0, 1);
    wr(4'h0, 8'h60);
    pin(1'b1, 1);
    pin(1'b0, 1);
    // Mid-run reset must bring back factory config and clear mask
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h0, 8'h6c);
    rd(4'h2, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wrap_up;
  end
endmodule
